// File: verilog/lcc_params.svh
// constants of the block check accumulator
// Function
// - longitudinal 8-bit mode: bitwise sum over characters
// - each shift: lsb xor, into top, shift right
// - data applied serially, lsb first, before shift
// - 12-bit cyclic mode over 6-bit characters
// - quotient loads stage 11, taps 10,9,8,0
// - quotient settles first; shift captures xor results
// - international 16-bit cyclic mode, 8-bit characters
// - 16-bit cyclic mode, 8-bit characters
// - received check value appended gives all zeros
// - one 16-stage register, feedback chosen by mode
// - active stages equal the generator degree
// - new block starts from all zeros
// - zero-power term is the leftmost active bit
// - check register read-only; restore through data
// - step write gives one shift while character bits remain; clear wins
// - readable quotient: data lsb xor check lsb
// - clear zeroes check, sets done; reset too
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

`define LCC_OFF_CSR       8'h00
`define LCC_OFF_CHECK     8'h04
`define LCC_OFF_DATA      8'h08

`define LCC_CSR_PERMIT    0
`define LCC_CSR_MODE_LO   1
`define LCC_CSR_MODE_HI   3
`define LCC_CSR_CLEAR     4
`define LCC_CSR_STEP      5
`define LCC_CSR_QUO       6
`define LCC_CSR_DONE      7

`define LCC_MODE_LRC8     3'h0
`define LCC_MODE_LRC16    3'h1
`define LCC_MODE_CRC12    3'h2
`define LCC_MODE_CRC16    3'h3
`define LCC_MODE_CCITT    3'h4

`define LCC_TAPS_LRC8     16'h0080
`define LCC_TAPS_LRC16    16'h8000
`define LCC_TAPS_CRC12    16'h0F01
`define LCC_TAPS_CRC16    16'hA001
`define LCC_TAPS_CCITT    16'h8408

`define LCC_WIDTH_8       16'h00FF
`define LCC_WIDTH_12      16'h0FFF
`define LCC_WIDTH_16      16'hFFFF

`define LCC_LEN_6         5'h06
`define LCC_LEN_8         5'h08
`define LCC_LEN_16        5'h10
`define LCC_LEN_LAST      5'h01
`define LCC_LEN_NONE      5'h00

`define LCC_CHECK_RST     16'h0000
`define LCC_DATA_RST      16'h0000
`define LCC_PERMIT_RST    1'h1
`define LCC_MODE_RST      3'h0
`define LCC_DONE_RST      1'h1
`define LCC_WORD_ZERO     32'h0000_0000

`endif

// File: verilog/lcc_pkg.sv
// types shared by the block check accumulator
`include "lcc_params.svh"
package lcc_pkg;

   typedef enum logic [2:0] {
      LCC_LRC8  = `LCC_MODE_LRC8,
      LCC_LRC16 = `LCC_MODE_LRC16,
      LCC_CRC12 = `LCC_MODE_CRC12,
      LCC_CRC16 = `LCC_MODE_CRC16,
      LCC_CCITT = `LCC_MODE_CCITT
   } lcc_mode_t;

   typedef struct packed {
      logic [15:0] taps;
      logic [15:0] wmask;
   } lcc_fb_cfg_t;

   typedef struct packed {
      logic       permit;
      logic [2:0] mode;
   } lcc_ctrl_t;

   typedef enum logic {
      LCC_ST_IDLE,
      LCC_ST_RUN
   } lcc_state_t;

endpackage

// File: verilog/lcc_feedback.sv
// feedback network of the check register
`timescale 1ns/100ps
`default_nettype none
module lcc_feedback (
   input  wire logic               [15:0] i_check,
   input  wire logic                      i_quotient,
   input  wire lcc_pkg::lcc_fb_cfg_t      i_cfg,
   output logic                    [15:0] o_next_check
);

   // per stage: shifted neighbour plus quotient tap
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_stage
         if (gi == 15) begin : g_top
            assign o_next_check[gi] = i_quotient & i_cfg.taps[gi];
         end else begin : g_mid
            assign o_next_check[gi] = (i_check[gi+1] & i_cfg.wmask[gi])
                                    ^ (i_quotient & i_cfg.taps[gi]);
         end
      end
   endgenerate

endmodule
`default_nettype wire

// File: verilog/lcc_top.sv
// block check accumulator with apb register slave
`timescale 1ns/100ps
`default_nettype none
`include "lcc_params.svh"
module lcc_top (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [3:0]  i_pstrb,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr
);

   // bus decode
   logic sel_csr;
   logic sel_check;
   logic sel_data;
   logic addr_ok;
   logic setup_phase;
   logic access_phase;
   logic rd_setup;
   logic wr_xfer;
   logic wr_csr;
   logic wr_data;
   logic clear_req;
   logic step_req;

   // control and status
   lcc_pkg::lcc_ctrl_t   ctrl;
   lcc_pkg::lcc_ctrl_t   next_ctrl;
   lcc_pkg::lcc_state_t  state;
   lcc_pkg::lcc_state_t  next_state;
   lcc_pkg::lcc_fb_cfg_t cfg;
   logic [4:0]           char_len;
   logic [4:0]           count;
   logic [4:0]           next_count;
   logic                 done;
   logic                 next_done;

   // datapath
   logic [15:0]          data;
   logic [15:0]          next_data;
   logic [15:0]          load_word;
   logic [15:0]          check;
   logic [15:0]          next_check;
   logic [15:0]          fb_check;
   logic                 quotient;
   logic                 shift_now;
   logic                 last_shift;
   logic                 run_active;
   logic [15:0]          next_wmask;

   // bus answer
   logic [31:0]          rd_word;
   logic [31:0]          csr_word;
   logic                 next_pready;
   logic [31:0]          next_prdata;
   logic                 next_pslverr;

   // address decode
   always_comb begin
      sel_csr   = (i_paddr == `LCC_OFF_CSR);
      sel_check = (i_paddr == `LCC_OFF_CHECK);
      sel_data  = (i_paddr == `LCC_OFF_DATA);
      addr_ok   = sel_csr | sel_check | sel_data;
   end

   // bus phases
   always_comb begin
      setup_phase  = i_psel & ~i_penable;
      access_phase = i_psel & i_penable;
      rd_setup     = setup_phase & ~i_pwrite;
   end

   // write strobes, taken at the access edge
   always_comb begin
      wr_xfer   = access_phase & o_pready & i_pwrite;
      wr_csr    = wr_xfer & sel_csr & i_pstrb[0];
      // check register has no write path
      wr_data   = wr_xfer & sel_data & (|i_pstrb[1:0]);
      clear_req = wr_csr & i_pwdata[`LCC_CSR_CLEAR];
      step_req  = wr_csr & i_pwdata[`LCC_CSR_STEP];
   end

   // mode selects taps, active width and character length
   always_comb begin
      unique case (ctrl.mode)
         `LCC_MODE_LRC8: begin
            cfg.taps  = `LCC_TAPS_LRC8;
            cfg.wmask = `LCC_WIDTH_8;
            char_len  = `LCC_LEN_8;
         end
         `LCC_MODE_LRC16: begin
            cfg.taps  = `LCC_TAPS_LRC16;
            cfg.wmask = `LCC_WIDTH_16;
            char_len  = `LCC_LEN_16;
         end
         `LCC_MODE_CRC12: begin
            cfg.taps  = `LCC_TAPS_CRC12;
            cfg.wmask = `LCC_WIDTH_12;
            char_len  = `LCC_LEN_6;
         end
         `LCC_MODE_CRC16: begin
            cfg.taps  = `LCC_TAPS_CRC16;
            cfg.wmask = `LCC_WIDTH_16;
            char_len  = `LCC_LEN_8;
         end
         `LCC_MODE_CCITT: begin
            cfg.taps  = `LCC_TAPS_CCITT;
            cfg.wmask = `LCC_WIDTH_16;
            char_len  = `LCC_LEN_8;
         end
         default: begin
            cfg.taps  = `LCC_TAPS_LRC16;
            cfg.wmask = `LCC_WIDTH_16;
            char_len  = `LCC_LEN_16;
         end
      endcase
   end

   // serial quotient
   always_comb begin
      quotient = data[0] ^ check[0];
   end

   // shift qualification
   always_comb begin
      run_active = (state == lcc_pkg::LCC_ST_RUN) && (count != `LCC_LEN_NONE);
      shift_now  = run_active && (ctrl.permit || step_req) && !clear_req;
      last_shift = shift_now && (count == `LCC_LEN_LAST);
   end

   // feedback network for the selected code
   lcc_feedback u_feedback (
      .i_check      (check),
      .i_quotient   (quotient),
      .i_cfg        (cfg),
      .o_next_check (fb_check)
   );

   // control register
   always_comb begin
      next_ctrl = ctrl;
      if (wr_csr) begin
         next_ctrl.permit = i_pwdata[`LCC_CSR_PERMIT];
         next_ctrl.mode   = i_pwdata[`LCC_CSR_MODE_HI:`LCC_CSR_MODE_LO];
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl.permit <= `LCC_PERMIT_RST;
         ctrl.mode   <= `LCC_MODE_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // active width of the code chosen by the next control value
   always_comb begin
      unique case (next_ctrl.mode)
         `LCC_MODE_LRC8: begin
            next_wmask = `LCC_WIDTH_8;
         end
         `LCC_MODE_LRC16: begin
            next_wmask = `LCC_WIDTH_16;
         end
         `LCC_MODE_CRC12: begin
            next_wmask = `LCC_WIDTH_12;
         end
         `LCC_MODE_CRC16: begin
            next_wmask = `LCC_WIDTH_16;
         end
         `LCC_MODE_CCITT: begin
            next_wmask = `LCC_WIDTH_16;
         end
         default: begin
            next_wmask = `LCC_WIDTH_16;
         end
      endcase
   end

   // sequencer: one shift per character bit
   always_comb begin
      next_state = state;
      next_count = count;
      unique case (state)
         lcc_pkg::LCC_ST_IDLE: begin
            if (wr_data) begin
               next_state = lcc_pkg::LCC_ST_RUN;
               next_count = char_len;
            end
         end
         lcc_pkg::LCC_ST_RUN: begin
            if (clear_req) begin
               next_state = lcc_pkg::LCC_ST_IDLE;
               next_count = `LCC_LEN_NONE;
            end else if (wr_data) begin
               next_count = char_len;
            end else if (last_shift) begin
               next_state = lcc_pkg::LCC_ST_IDLE;
               next_count = `LCC_LEN_NONE;
            end else if (shift_now) begin
               next_count = count - `LCC_LEN_LAST;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state <= lcc_pkg::LCC_ST_IDLE;
         count <= `LCC_LEN_NONE;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // completion flag
   always_comb begin
      next_done = done;
      if (wr_data) begin
         next_done = 1'b0;
      end
      if (last_shift && !wr_data) begin
         next_done = 1'b1;
      end
      if (clear_req) begin
         next_done = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         done <= `LCC_DONE_RST;
      end else begin
         done <= next_done;
      end
   end

   // byte lanes merged into the data register
   always_comb begin
      load_word = data;
      if (i_pstrb[0]) begin
         load_word[7:0] = i_pwdata[7:0];
      end
      if (i_pstrb[1]) begin
         load_word[15:8] = i_pwdata[15:8];
      end
   end

   // data register: parallel load, then shift right
   always_comb begin
      next_data = data;
      if (wr_data) begin
         next_data = load_word;
      end else if (shift_now) begin
         next_data = {1'b0, data[15:1]};
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         data <= `LCC_DATA_RST;
      end else begin
         data <= next_data;
      end
   end

   // check register
   always_comb begin
      next_check = check;
      if (clear_req) begin
         next_check = `LCC_CHECK_RST;
      end else if (shift_now) begin
         next_check = fb_check;
      end
      // a narrower code keeps its upper stages at zero
      next_check = next_check & next_wmask;
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         check <= `LCC_CHECK_RST;
      end else begin
         check <= next_check;
      end
   end

   // control word as read back; strobes read as zero
   always_comb begin
      csr_word                                     = `LCC_WORD_ZERO;
      csr_word[`LCC_CSR_PERMIT]                    = ctrl.permit;
      csr_word[`LCC_CSR_MODE_HI:`LCC_CSR_MODE_LO] = ctrl.mode;
      csr_word[`LCC_CSR_CLEAR]                     = 1'b0;
      csr_word[`LCC_CSR_STEP]                      = 1'b0;
      csr_word[`LCC_CSR_QUO]                       = quotient;
      csr_word[`LCC_CSR_DONE]                      = done;
   end

   // read multiplexer
   always_comb begin
      rd_word = `LCC_WORD_ZERO;
      if (sel_csr) begin
         rd_word = csr_word;
      end else if (sel_check) begin
         rd_word[15:0] = check;
      end else if (sel_data) begin
         rd_word[15:0] = data;
      end
   end

   // apb answer: one access cycle, no wait states
   always_comb begin
      next_pready  = setup_phase;
      next_pslverr = setup_phase & ~addr_ok;
   end

   // read data captured at the setup edge
   always_comb begin
      next_prdata = `LCC_WORD_ZERO;
      if (rd_setup) begin
         next_prdata = rd_word;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= `LCC_WORD_ZERO;
      end else begin
         o_pready  <= next_pready;
         o_pslverr <= next_pslverr;
         o_prdata  <= next_prdata;
      end
   end

endmodule
`default_nettype wire

// File: verif/lcc_chk.sv
// bus-level checks of the block check accumulator
`timescale 1ns/100ps
`default_nettype none
module lcc_chk (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic [3:0]  i_pstrb,
   input  wire logic        o_pready,
   input  wire logic [31:0] o_prdata,
   input  wire logic        o_pslverr
);
   logic setup;
   logic rd;
   logic wr;
   logic mapped;
   assign setup  = i_psel & ~i_penable;
   assign rd     = setup & ~i_pwrite;
   assign wr     = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0];
   assign mapped = (i_paddr == 8'h00) || (i_paddr == 8'h04) || (i_paddr == 8'h08);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   AST_ZERO_WAIT: assert property (setup |=> o_pready)
      else $error("ready missing after setup");
   AST_READY_PULSE: assert property (o_pready |=> !o_pready)
      else $error("ready held too long");
   AST_UNMAPPED: assert property (setup && !mapped |=> o_pslverr && o_prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_RDATA_QUIET: assert property (!rd |=> o_prdata == 32'h0)
      else $error("read data outside read");
   AST_CSR_READ: assert property (rd && i_paddr == 8'h00 |=> o_prdata[31:8] == 24'h0 && o_prdata[5:4] == 2'h0)
      else $error("control word bad");
   AST_CHECK_READ: assert property (rd && i_paddr == 8'h04 |=> o_prdata[31:16] == 16'h0)
      else $error("check word too wide");
   AST_CLEAR_DONE: assert property (wr && i_paddr == 8'h00 && i_pwdata[4] ##2 rd && i_paddr == 8'h00 |=> o_prdata[7])
      else $error("done not set by clear");
   AST_CLEAR_ZERO: assert property (wr && i_paddr == 8'h00 && i_pwdata[4] ##2 rd && i_paddr == 8'h04 |=> o_prdata[15:0] == 16'h0)
      else $error("check not zero after clear");
   AST_DATA_BUSY: assert property (wr && i_paddr == 8'h08 ##2 rd && i_paddr == 8'h00 |=> !o_prdata[7])
      else $error("done set too early");
endmodule
bind lcc_top lcc_chk chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready),
   .o_prdata(o_prdata), .o_pslverr(o_pslverr));
`default_nettype wire

// File: verif/lcc_host.sv
// apb host model feeding characters to the accumulator
`timescale 1ns/100ps
`default_nettype none
module lcc_host (
   input  wire logic        i_clk,
   input  wire logic        i_pready,
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pslverr,
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic [7:0]       o_paddr,
   output logic [31:0]      o_pwdata,
   output logic [3:0]       o_pstrb
);
   logic [31:0] rdata;
   logic        err;
   initial begin
      o_psel    = 1'b0;
      o_penable = 1'b0;
      o_pwrite  = 1'b0;
      o_paddr   = 8'h00;
      o_pwdata  = 32'h0;
      o_pstrb   = 4'hF;
   end
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_clk);
      o_psel    <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite  <= wr;
      o_paddr   <= a;
      o_pwdata  <= wd;
      @(posedge i_clk);
      o_penable <= 1'b1;
      do @(posedge i_clk); while (i_pready !== 1'b1);
      rdata = i_prdata;
      err = i_pslverr;
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
      o_paddr   <= ~a;
      o_pwdata  <= ~wd;
   endtask
   // right-justified character, then poll done
   task automatic load(input logic [15:0] c);
      int k;
      k = 0;
      xfer(1'b1, 8'h08, {16'h0, c});
      do begin
         xfer(1'b0, 8'h00, 32'h0);
         k++;
      end while (rdata[7] !== 1'b1 && k < 40);
   endtask
   // check value after the message, low chunk first
   task automatic append(input logic [15:0] v, input int n, input int k);
      for (int i = 0; i < k; i++) begin
         load(16'((v >> (i * n)) & ((1 << n) - 1)));
      end
   endtask
   task automatic restore(input logic [15:0] p);
      xfer(1'b1, 8'h00, 32'h13);
      load(p);
   endtask
endmodule
`default_nettype wire

// File: verif/test_lrc_crc_check_accumulator.sv
// self-checking bench of the block check accumulator
`timescale 1ns/100ps
`default_nettype none
module test_lrc_crc_check_accumulator;
   logic        i_clk = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   int          num_errors, total_checks, d, mchk;
   int          taps [5] = '{32'h80, 32'h8000, 32'hF01, 32'hA001, 32'h8408};
   int          lens [5] = '{8, 16, 6, 8, 8};
   int          wmsk [5] = '{32'hFF, 32'hFFFF, 32'hFFF, 32'hFFFF, 32'hFFFF};

   lcc_top dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr));
   lcc_host host_u (.i_clk(i_clk), .i_pready(pready), .i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel),
      .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));

   always #25 i_clk = ~i_clk;

   // reference accumulator, one shift per bit
   function automatic int acc(int m, int c, int dv, int n);
      int q;
      for (int i = 0; i < n; i++) begin
         q = ((dv >> i) ^ c) & 1;
         c = ((c >> 1) & wmsk[m]) ^ (q ? taps[m] : 0);
      end
      return c;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      host_u.xfer(1'b0, a, 32'h0);
      check(host_u.rdata, exp);
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #500000;
      num_errors++;
      end_sim();
   end
   initial begin
      void'($urandom(32'h7D70));
      repeat (8) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(8'h00, 32'h81);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'h0);
      check(host_u.err, 32'h1);
      host_u.xfer(1'b1, 8'h04, 32'hFFFF);
      rd(8'h04, 32'h0);
      for (int m = 0; m < 5; m++) begin
         host_u.xfer(1'b1, 8'h00, 32'h11 | (m << 1));
         rd(8'h04, 32'h0);
         mchk = 0;
         for (int n = 0; n < 4; n++) begin
            d = $urandom & ((1 << lens[m]) - 1);
            host_u.load(16'(d));
            mchk = acc(m, mchk, d, lens[m]);
            rd(8'h04, mchk);
         end
         host_u.append(16'(mchk), lens[m], (m < 2) ? 1 : 2);
         rd(8'h04, 32'h0);
      end
      host_u.xfer(1'b1, 8'h00, 32'h16);
      rd(8'h00, 32'h86);
      d = $urandom & 32'hFF;
      mchk = 0;
      host_u.xfer(1'b1, 8'h08, d);
      for (int i = 0; i < 8; i++) begin
         rd(8'h00, 32'h06 | ((((d >> i) ^ mchk) & 1) << 6));
         host_u.xfer(1'b1, 8'h00, 32'h26);
         mchk = acc(3, mchk, d >> i, 1);
         rd(8'h04, mchk);
      end
      host_u.xfer(1'b1, 8'h00, 32'h26);
      rd(8'h04, mchk);
      rd(8'h00, 32'h86 | ((mchk & 1) << 6));
      d = $urandom & 32'hFFFF;
      host_u.restore(16'(d));
      rd(8'h04, d);
      host_u.xfer(1'b1, 8'h00, 32'h07);
      mchk = $urandom & 32'hFF;
      host_u.load(16'(mchk));
      rd(8'h04, acc(3, d, mchk, 8));
      end_sim();
   end
endmodule
`default_nettype wire
